// [rtl/gpio_and_powerup_strap_logic.sv]
// Sixteen-pin general purpose port with fixed status pins and strap capture
`include "gpio_strap_cfg.svh"
`default_nettype none
module gpio_and_powerup_strap_logic
    import strap_pkg::*;
#(
    parameter int unsigned STABLE_CYCLES = `STRAP_STABLE_CYCLES
)
(
    input  wire logic        ref_clk,             // Reference clock, 100 MHz
    input  wire logic        resetn,              // Fundamental reset, active low
    input  wire logic        clk_en,              // Freezes all state but the reset synchroniser while low
    input  wire logic [15:0] pad_in,              // Pin levels
    output logic      [15:0] pad_out,             // Pin drive levels
    output logic      [15:0] pad_oe_n,            // Low while a pin is driven
    input  wire logic [15:0] gpio_dir_out,        // 1 makes a pin an output
    input  wire logic [15:3] gpio_sw_level,       // Software levels, pins 15:3
    output logic      [15:0] gpio_in_level,       // Sampled pin levels
    input  wire logic        block_dma_unit_ecc,  // Uncorrectable ECC error
    input  wire logic        messaging_unit_ecc,  // Uncorrectable ECC error
    input  wire logic        pcie_to_rio_path_ecc, // Uncorrectable ECC error
    input  wire logic        rio_to_pcie_path_ecc, // Uncorrectable ECC error
    input  wire logic        mac_ctrl_mem_ecc,    // MAC non-data memory ECC error
    input  wire logic        pcie_dl_active,      // PCIe data link active
    input  wire logic        irq_active,          // Any interrupt active
    input  wire logic        clock_mode_strap,    // Static clock mode pin
    input  wire logic        i2c_addr_wr_en,      // Slave config write strobe
    input  wire logic [6:0]  i2c_addr_wr_data,    // New I2C target address
    output logic             strap_valid,         // Straps captured
    output logic             pcie_common_clock,   // Common clocked mode
    output var refclk_freq_e refclk_freq_select,  // Decoded reference rate
    output logic             refclk_reserved,     // Reserved select code
    output logic             rio_3g125_allowed,   // 3.125 Gbaud usable
    output logic             eeprom_load_en,      // Boot load from EEPROM
    output logic             eeprom_two_byte_addr, // Two EEPROM address bytes
    output logic             boot_by_root_complex, // No EEPROM, root complex
    output logic             boot_by_ext_i2c,     // No EEPROM, external master
    output logic      [6:0]  eeprom_dev_addr,     // EEPROM device address
    output logic      [6:0]  i2c_target_addr,     // Own I2C slave address
    output logic      [1:0]  rx_lane_swap_code,   // Receive swap reset value
    output logic             tx_lane_swap_strap,  // Transmit swap reset value
    output logic             link_host_strap,     // Host reset value
    output logic      [7:0]  base_id,             // Base ID reset value
    output logic      [15:0] large_base_id        // Large base ID reset value
);
    logic        rst_meta_reg;
    logic        rst_n;
    logic [12:0] sv;
    logic [1:0]  clksel;
    logic        ecc_any;
    logic        addr_width;
    logic        inhibit;

    strap_if sif ();

    // Asynchronous assert, synchronous release
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    assign sif.pin_lvl = pad_in[`STRAP_PINS-1:0];

    strap_latch #(
        .STABLE_CYCLES (STABLE_CYCLES)
    ) u_strap_latch (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .sif     (sif)
    );

    assign sv         = sif.strap_val;
    assign clksel     = sv[`STRAP_CLKSEL_HI:`STRAP_CLKSEL_LO];
    assign addr_width = sv[`STRAP_ADDR_WIDTH];
    assign inhibit    = sv[`STRAP_LOAD_INHIBIT];
    assign ecc_any    = block_dma_unit_ecc | messaging_unit_ecc | pcie_to_rio_path_ecc
                      | rio_to_pcie_path_ecc | mac_ctrl_mem_ecc;

    // Pins stay undriven until the straps are taken, so the board sees no contention
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            pad_oe_n <= '1;
        else if (clk_en)
            pad_oe_n <= sif.done ? ~gpio_dir_out : '1;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            pad_out <= '0;
        else if (clk_en)
        begin
            pad_out[`PIN_ECC]                <= ecc_any;
            pad_out[`PIN_LINK_DOWN]          <= ~pcie_dl_active;
            pad_out[`PIN_IRQ]                <= irq_active;
            pad_out[`PIN_SW_HI:`PIN_SW_LO]   <= gpio_sw_level;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            gpio_in_level <= '0;
        else if (clk_en)
            gpio_in_level <= pad_in;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strap_valid        <= 1'b0;
            pcie_common_clock  <= 1'b0;
            refclk_freq_select <= REF_RESERVED;
            refclk_reserved    <= 1'b1;
            rio_3g125_allowed  <= 1'b0;
        end
        else if (clk_en)
        begin
            strap_valid       <= sif.done;
            // Static pin; sampled every cycle as it never moves in service
            pcie_common_clock <= clock_mode_strap;
            if (clksel == `CLKSEL_125)
                refclk_freq_select <= REF_125M;
            else if (clksel == `CLKSEL_100)
                refclk_freq_select <= REF_100M;
            else if (clksel == `CLKSEL_156)
                refclk_freq_select <= REF_156M25;
            else
                refclk_freq_select <= REF_RESERVED;
            refclk_reserved   <= !(clksel == `CLKSEL_125 || clksel == `CLKSEL_100
                                   || clksel == `CLKSEL_156);
            rio_3g125_allowed <= (clksel == `CLKSEL_125) || (clksel == `CLKSEL_156);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            eeprom_load_en       <= 1'b0;
            eeprom_two_byte_addr <= 1'b0;
            boot_by_root_complex <= 1'b0;
            boot_by_ext_i2c      <= 1'b0;
            eeprom_dev_addr      <= '0;
        end
        else if (clk_en)
        begin
            // Held off until capture so a loader never starts on stale straps
            eeprom_load_en       <= sif.done && !inhibit;
            eeprom_two_byte_addr <= !inhibit && addr_width;
            boot_by_root_complex <= sif.done && inhibit && !addr_width;
            boot_by_ext_i2c      <= sif.done && inhibit && addr_width;
            eeprom_dev_addr      <= {`EEPROM_ADDR_UPPER,
                                     sv[`STRAP_EEPROM_SEL] ? sv[1:0] : `EEPROM_ADDR_LOW_DEF};
        end
    end

    // Software write wins; until capture the address is reloaded from the live strap pins every cycle
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            i2c_target_addr <= '0;
        else if (clk_en)
        begin
            if (i2c_addr_wr_en)
                i2c_target_addr <= i2c_addr_wr_data;
            else if (!sif.done)
                i2c_target_addr <= {`I2C_TGT_ADDR_UPPER,
                                    sif.pin_lvl[`STRAP_I2C_ADDR_HI:`STRAP_I2C_ADDR_LO]};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_lane_swap_code  <= `RX_SWAP_OFF;
            tx_lane_swap_strap <= 1'b0;
            link_host_strap    <= 1'b0;
            base_id            <= '0;
            large_base_id      <= '0;
        end
        else if (clk_en)
        begin
            rx_lane_swap_code  <= sv[`STRAP_RX_SWAP] ? `RX_SWAP_ON : `RX_SWAP_OFF;
            tx_lane_swap_strap <= sv[`STRAP_TX_SWAP];
            link_host_strap    <= sv[`STRAP_HOST];
            if (sv[`STRAP_HOST])
            begin
                base_id       <= {7'h00, sv[`STRAP_BASE_ID]};
                large_base_id <= {15'h0000, sv[`STRAP_BASE_ID]};
            end
            else if (sv[`STRAP_BASE_ID])
            begin
                base_id       <= `BASE_ID_ONES;
                large_base_id <= `LARGE_ID_ONES;
            end
            else
            begin
                base_id       <= `BASE_ID_DEFAULT;
                large_base_id <= `LARGE_ID_DEFAULT;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Sampled rst_n in antecedents: flops still reset on the release edge itself

    property p_dir;
        (clk_en && sif.done) |=> (pad_oe_n == ~$past(gpio_dir_out));
    endproperty
    a_dir: assert property (p_dir) else $error("pin direction not followed");

    property p_ecc;
        (clk_en && rst_n && ecc_any) |=> pad_out[`PIN_ECC];
    endproperty
    a_ecc: assert property (p_ecc) else $error("ECC pin not raised");

    property p_link;
        (clk_en && !pcie_dl_active) ##1 (!pad_oe_n[`PIN_LINK_DOWN]) |-> pad_out[`PIN_LINK_DOWN];
    endproperty
    a_link: assert property (p_link) else $error("link-down pin not driven high");

    property p_irq;
        (clk_en && rst_n) |=> (pad_out[`PIN_IRQ] == $past(irq_active));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt pin wrong");

    property p_sw;
        (clk_en && rst_n) |=> (pad_out[`PIN_SW_HI:`PIN_SW_LO] == $past(gpio_sw_level));
    endproperty
    a_sw: assert property (p_sw) else $error("software level not on pins");

    property p_window;
        !sif.done |=> (pad_oe_n == 16'hffff);
    endproperty
    a_window: assert property (p_window) else $error("pin driven during strap window");

    property p_hold;
        sif.done |=> (sif.done && $stable(sif.strap_val));
    endproperty
    a_hold: assert property (p_hold) else $error("captured strap changed");

    property p_load;
        (clk_en && sif.done && inhibit) |=> !eeprom_load_en ##1 !eeprom_load_en;
    endproperty
    a_load: assert property (p_load) else $error("EEPROM load despite inhibit");

    property p_boot_src;
        (clk_en && sif.done && inhibit) |=> (boot_by_ext_i2c != boot_by_root_complex);
    endproperty
    a_boot_src: assert property (p_boot_src) else $error("boot source not unique");

    property p_ref;
        (clk_en && sif.done && clksel == `CLKSEL_100) |=> (refclk_freq_select == REF_100M)
            && !rio_3g125_allowed;
    endproperty
    a_ref: assert property (p_ref) else $error("100 MHz decode wrong");

    property p_eeprom_addr;
        (clk_en && rst_n) |=> (eeprom_dev_addr[6:2] == `EEPROM_ADDR_UPPER);
    endproperty
    a_eeprom_addr: assert property (p_eeprom_addr) else $error("EEPROM upper address wrong");

    property p_override;
        (clk_en && rst_n && i2c_addr_wr_en) |=> (i2c_target_addr == $past(i2c_addr_wr_data));
    endproperty
    a_override: assert property (p_override) else $error("I2C address not replaced");

    c_capture:  cover property ($rose(sif.done));
    c_override: cover property (sif.done && clk_en && i2c_addr_wr_en);
    c_ecc_pin:  cover property (!pad_oe_n[`PIN_ECC] && pad_out[`PIN_ECC]);
    c_load:     cover property ($rose(eeprom_load_en));
endmodule : gpio_and_powerup_strap_logic
`default_nettype wire

// [rtl/gpio_strap_cfg.svh]
// Constants for the general purpose pin and power-up strap block
`ifndef GPIO_STRAP_CFG_SVH
`define GPIO_STRAP_CFG_SVH

`define GPIO_PINS            16
`define STRAP_PINS           13
`define STRAP_STABLE_CYCLES  4000
`define PIN_ECC              0
`define PIN_LINK_DOWN        1
`define PIN_IRQ              2
`define PIN_SW_LO            3
`define PIN_SW_HI            15
`define STRAP_I2C_ADDR_HI    3
`define STRAP_I2C_ADDR_LO    0
`define STRAP_LOAD_INHIBIT   4
`define STRAP_EEPROM_SEL     5
`define STRAP_ADDR_WIDTH     6
`define STRAP_RX_SWAP        7
`define STRAP_TX_SWAP        8
`define STRAP_HOST           9
`define STRAP_BASE_ID        10
`define STRAP_CLKSEL_HI      12
`define STRAP_CLKSEL_LO      11
`define CLKSEL_125           2'h3
`define CLKSEL_100           2'h2
`define CLKSEL_156           2'h1
`define EEPROM_ADDR_UPPER    5'h14
`define EEPROM_ADDR_LOW_DEF  2'h0
`define I2C_TGT_ADDR_UPPER   3'h5
`define RX_SWAP_ON           2'h2
`define RX_SWAP_OFF          2'h0
`define BASE_ID_ONES         8'hff
`define BASE_ID_DEFAULT      8'hfe
`define LARGE_ID_ONES        16'hffff
`define LARGE_ID_DEFAULT     16'h00fe

`endif

// [rtl/strap_if.sv]
// Carrier between the pin logic and the strap capture unit
`default_nettype none
interface strap_if;
    logic [12:0] pin_lvl;
    logic [12:0] strap_val;
    logic        done;

    modport latch
    (
        input  pin_lvl,
        output strap_val,
        output done
    );
    modport core
    (
        output pin_lvl,
        input  strap_val,
        input  done
    );
endinterface : strap_if
`default_nettype wire

// [rtl/strap_latch.sv]
// Post-reset stability counter and strap holding flops
`include "gpio_strap_cfg.svh"
`default_nettype none
module strap_latch
    import strap_pkg::*;
#(
    parameter int unsigned STABLE_CYCLES = `STRAP_STABLE_CYCLES
)
(
    input  wire logic ref_clk, // Reference clock
    input  wire logic rst_n,   // Synchronised reset, active low
    input  wire logic clk_en,  // Freezes state while low
    strap_if.latch    sif      // Pin levels in, straps out
);
    localparam int CW = $clog2(STABLE_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(STABLE_CYCLES - 1);

    strap_phase_e   phase_reg;
    logic [CW-1:0]  count_reg;
    logic [12:0]    strap_reg;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_reg <= ST_COUNT;
            count_reg <= '0;
        end
        else if (clk_en)
        begin
            case (phase_reg)
                ST_COUNT:
                begin
                    count_reg <= count_reg + CW'(1);
                    if (count_reg == LAST)
                        phase_reg <= ST_CAPTURE;
                end
                ST_CAPTURE: phase_reg <= ST_HOLD;
                default:    phase_reg <= ST_HOLD; // Held until next reset
            endcase
        end
    end

    // Pins are looked at once, then disregarded
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            strap_reg <= '0;
        else if (clk_en && phase_reg == ST_CAPTURE)
            strap_reg <= sif.pin_lvl;
    end

    assign sif.strap_val = strap_reg;
    assign sif.done      = (phase_reg == ST_HOLD);
endmodule : strap_latch
`default_nettype wire

// [rtl/strap_pkg.sv]
// Types shared by the strap capture and pin logic
`default_nettype none
package strap_pkg;
    typedef enum logic [1:0]
    {
        ST_COUNT   = 2'h0,
        ST_CAPTURE = 2'h1,
        ST_HOLD    = 2'h3
    } strap_phase_e;

    typedef enum logic [1:0]
    {
        REF_RESERVED = 2'h0,
        REF_156M25   = 2'h1,
        REF_100M     = 2'h2,
        REF_125M     = 2'h3
    } refclk_freq_e;
endpackage : strap_pkg
`default_nettype wire

// [verif/strap_board.sv]
// Board model: strap resistors and external logic on the sixteen pins
`default_nettype none
module strap_board
(
    input  wire logic [12:0] strap_lvl, // Strap resistor levels
    input  wire logic        hold,      // High while straps must stand
    input  wire logic [15:0] ext_lvl,   // External logic levels
    input  wire logic [15:0] pad_out,   // Device drive levels
    input  wire logic [15:0] pad_oe_n,  // Low where the device drives
    output logic      [15:0] pad_in     // Resolved pin levels
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] board_lvl;

    // Straps stand unchanged through the whole window
    assign board_lvl = hold ? {ext_lvl[15:13], strap_lvl} : ext_lvl;

    // Board yields wherever the device drives
    always_comb
    begin
        for (int i = 0; i < 16; i++)
        begin
            pad_in[i] = pad_oe_n[i] ? board_lvl[i] : pad_out[i];
        end
    end
endmodule : strap_board
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the pin and strap block
`include "gpio_strap_cfg.svh"
`default_nettype none
module tb_top
    import strap_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int STABLE_N = 8;

    logic         ref_clk, resetn, clk_en, hold, strap_valid, pcie_common_clock;
    logic [15:0]  pad_in, pad_out, pad_oe_n, gpio_dir_out, gpio_in_level, ext_lvl;
    logic [15:3]  gpio_sw_level;
    logic [4:0]   ecc;
    logic         pcie_dl_active, irq_active, clock_mode_strap, i2c_addr_wr_en;
    logic [6:0]   i2c_addr_wr_data, eeprom_dev_addr, i2c_target_addr;
    logic [12:0]  strap_lvl;
    refclk_freq_e refclk_freq_select;
    logic         refclk_reserved, rio_3g125_allowed, eeprom_load_en, eeprom_two_byte_addr;
    logic         boot_by_root_complex, boot_by_ext_i2c, tx_lane_swap_strap, link_host_strap;
    logic [1:0]   rx_lane_swap_code;
    logic [7:0]   base_id;
    logic [15:0]  large_base_id;
    logic [49:0]  strap_seen;
    int           err_total, comparisons;
    integer       seed;

    assign strap_seen = {refclk_freq_select, refclk_reserved, rio_3g125_allowed, eeprom_load_en,
                         eeprom_two_byte_addr, boot_by_root_complex, boot_by_ext_i2c, eeprom_dev_addr,
                         i2c_target_addr, rx_lane_swap_code, tx_lane_swap_strap, link_host_strap,
                         base_id, large_base_id};

    gpio_and_powerup_strap_logic #(.STABLE_CYCLES(STABLE_N)) dut_u
    (
        .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe_n(pad_oe_n), .gpio_dir_out(gpio_dir_out), .gpio_sw_level(gpio_sw_level),
        .gpio_in_level(gpio_in_level), .block_dma_unit_ecc(ecc[0]), .messaging_unit_ecc(ecc[1]),
        .pcie_to_rio_path_ecc(ecc[2]), .rio_to_pcie_path_ecc(ecc[3]), .mac_ctrl_mem_ecc(ecc[4]),
        .pcie_dl_active(pcie_dl_active), .irq_active(irq_active), .clock_mode_strap(clock_mode_strap),
        .i2c_addr_wr_en(i2c_addr_wr_en), .i2c_addr_wr_data(i2c_addr_wr_data), .strap_valid(strap_valid),
        .pcie_common_clock(pcie_common_clock), .refclk_freq_select(refclk_freq_select),
        .refclk_reserved(refclk_reserved), .rio_3g125_allowed(rio_3g125_allowed),
        .eeprom_load_en(eeprom_load_en), .eeprom_two_byte_addr(eeprom_two_byte_addr),
        .boot_by_root_complex(boot_by_root_complex), .boot_by_ext_i2c(boot_by_ext_i2c),
        .eeprom_dev_addr(eeprom_dev_addr), .i2c_target_addr(i2c_target_addr),
        .rx_lane_swap_code(rx_lane_swap_code), .tx_lane_swap_strap(tx_lane_swap_strap),
        .link_host_strap(link_host_strap), .base_id(base_id), .large_base_id(large_base_id)
    );

    strap_board board_u
    (
        .strap_lvl(strap_lvl), .hold(hold), .ext_lvl(ext_lvl),
        .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_in(pad_in)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Reference decode of a strap word, written from the pin mapping
    function automatic logic [49:0] strap_model(input logic [12:0] s);
        logic [1:0]  sel;
        logic [7:0]  bid;
        logic [15:0] lid;
        sel = s[12:11];
        bid = s[9] ? {7'h00, s[10]} : (s[10] ? 8'hff : 8'hfe);
        lid = s[9] ? {15'h0000, s[10]} : (s[10] ? 16'hffff : 16'h00fe);
        return {sel, sel == 2'h0, sel[0], !s[4], !s[4] & s[6], s[4] & !s[6], s[4] & s[6], 5'h14,
                s[5] ? s[1:0] : 2'h0, 3'h5, s[3:0], s[7] ? 2'h2 : 2'h0, s[8], s[9], bid, lid};
    endfunction : strap_model

    task automatic drive_random();
        ext_lvl          <= 16'($random(seed));
        gpio_dir_out     <= 16'($random(seed));
        gpio_sw_level    <= 13'($random(seed));
        ecc              <= 5'h01 << ($random(seed) & 32'h7);
        pcie_dl_active   <= 1'($random(seed));
        irq_active       <= 1'($random(seed));
        clock_mode_strap <= 1'($random(seed));
    endtask : drive_random

    // Outputs land one edge after the inputs they follow; a low enable holds them
    task automatic pin_phase(input int n);
        logic [48:0] exp_q [$];
        logic [48:0] last;
        for (int k = 0; k < n; k++)
        begin
            @(posedge ref_clk);
            hold   <= 1'b0;
            clk_en <= (k == 0) || ($random(seed) % 4 != 0);
            drive_random();
            @(negedge ref_clk);
            if (exp_q.size() > 0)
                chk("pins", {pad_out, pad_oe_n, gpio_in_level, pcie_common_clock}, exp_q.pop_front()); // Pins
            if (clk_en)
                last = {gpio_sw_level, irq_active, !pcie_dl_active, |ecc, ~gpio_dir_out, pad_in,
                        clock_mode_strap};
            exp_q.push_back(last);
        end
    endtask : pin_phase

    task automatic run_case(input logic [12:0] s);
        int cnt;
        logic [6:0] a1, a2;
        @(posedge ref_clk);
        resetn    <= 1'b0;
        hold      <= 1'b1;
        strap_lvl <= s;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        cnt = 0;
        while (strap_valid !== 1'b1 && cnt < 100)
        begin
            @(posedge ref_clk);
            drive_random();
            @(negedge ref_clk);
            cnt++;
            if (cnt <= STABLE_N)
                chk("window_oe_n", pad_oe_n, 16'hffff); // No drive in window
        end
        // Two synchroniser edges, the count, the capture edge, then valid
        chk("window_len", cnt, STABLE_N + 4); // Window length
        chk("straps", strap_seen, strap_model(s)); // Decode
        pin_phase(16);
        chk("straps_held", strap_seen, strap_model(s)); // Pins free later
        a1 = 7'($random(seed));
        a2 = 7'($random(seed));
        @(posedge ref_clk);
        clk_en           <= 1'b1;
        i2c_addr_wr_en   <= 1'b1;
        i2c_addr_wr_data <= a1;
        @(posedge ref_clk);
        i2c_addr_wr_data <= a2;
        @(negedge ref_clk);
        chk("i2c_addr_1", i2c_target_addr, a1); // Software address
        @(posedge ref_clk);
        i2c_addr_wr_en <= 1'b0;
        @(negedge ref_clk);
        chk("i2c_addr_2", i2c_target_addr, a2); // Back to back write
    endtask : run_case

    initial
    begin
        logic [12:0] s;
        seed             = 32'h0eeacf2a;
        err_total        = 0;
        comparisons      = 0;
        resetn           = 1'b0;
        clk_en           = 1'b1;
        hold             = 1'b1;
        strap_lvl        = 13'h0000;
        ext_lvl          = 16'h0000;
        gpio_dir_out     = 16'h0000;
        gpio_sw_level    = 13'h0000;
        ecc              = 5'h00;
        pcie_dl_active   = 1'b0;
        irq_active       = 1'b0;
        clock_mode_strap = 1'b0;
        i2c_addr_wr_en   = 1'b0;
        i2c_addr_wr_data = 7'h00;
        for (int i = 0; i < 16; i++)
        begin
            s        = 13'($random(seed));
            s[12:11] = i[1:0];
            s[10:9]  = i[3:2];
            s[4]     = i[2] ^ i[0];
            s[6]     = i[3] ^ i[1];
            run_case(s);
        end
        end_of_test();
    end

    // Whole run needs under ten microseconds
    initial
    begin
        #100000;
        err_total++;
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
